// ==== hdl/dac_channel.sv ====
/*
 * one converter channel: value register, applied code, trigger gating.
 * assumes: trigger is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ns
module dac_channel (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_enable,
   input  wire logic       i_realtime,
   input  wire logic       i_trigger,
   output logic      [7:0] o_applied,
   output logic            o_pending,
   output logic      [7:0] o_code,
   output logic            o_drive
);
   logic [7:0] written;

   ////////////////////////////////////////////////////////////////////
   // written value, whole byte only
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         written <= dac_ctrl_pkg::RESET_VALUE;
      end else if (i_wr) begin
         written <= i_wdata;
      end
   end

   // pending flag: a write wins over a trigger in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pending <= 1'b0;
      end else if (i_wr && i_realtime) begin
         o_pending <= 1'b1;
      end else if (i_trigger || !i_realtime) begin
         o_pending <= 1'b0;
      end
   end

   // applied value: straight through in normal mode, on trigger otherwise
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_applied <= dac_ctrl_pkg::RESET_VALUE;
      end else if (!i_realtime && i_wr) begin
         o_applied <= i_wdata;
      end else if (!i_realtime) begin
         o_applied <= written;
      end else if (i_trigger && o_pending) begin
         o_applied <= written;
      end
   end

   // output code and drive, high impedance when disabled
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_code  <= dac_ctrl_pkg::RESET_VALUE;
         o_drive <= 1'b0;
      end else begin
         o_code  <= o_applied;
         o_drive <= i_enable;
      end
   end
endmodule : dac_channel

// ==== hdl/dac_ctrl.sv ====
/*
 * two-channel 8-bit converter control: value registers, mode register,
 * normal and triggered output, register port.
 * assumes: timer events are one-cycle pulses on I_REF_CLK; the analog
 * ladder outside turns O_ANALOG_OUTn codes into reference*code/256.
 */
// The plain strobed port and the register addresses were left to the implementer.
//Contract
//- each channel holds an 8-bit value; output equals reference times value over 256.
//- reset clears both channel value registers to zero.
//- channel value registers are written as whole bytes only.
//- realtime mode reads return the applied value until the trigger.
//- mode register resets to zero, writable per bit or whole byte.
//- disabled channel leaves its analog output high impedance.
//- timer 1 event triggers channel 0, timer 2 event triggers channel 1.
//- mode bit 4 selects channel 0 mode, bit 5 channel 1 mode.
//- each channel converts when its own enable bit is set.
//- normal mode applies a written value at once and holds it.
//- realtime mode holds a new value pending until the next trigger.
`timescale 1ns/1ns
module dac_ctrl (
   input  wire logic       I_REF_CLK,
   input  wire logic       I_RST,
   input  wire logic [1:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output logic      [7:0] O_RDATA,
   input  wire logic       I_TIMER1_EVENT,
   input  wire logic       I_TIMER2_EVENT,
   input  wire logic       I_BIT_WR,
   input  wire logic [2:0] I_BIT_POS,
   input  wire logic       I_BIT_VAL,
   output logic      [7:0] O_ANALOG_OUT0,
   output logic            O_ANALOG_OUT0_OE,
   output logic      [7:0] O_ANALOG_OUT1,
   output logic            O_ANALOG_OUT1_OE,
   output logic            O_CHAN0_PENDING,
   output logic            O_CHAN1_PENDING
);
   logic [7:0] converter_mode_ctrl;
   logic [7:0] chan0_value;
   logic [7:0] chan1_value;
   logic       chan0_enable;
   logic       chan1_enable;
   logic       chan0_mode_sel;
   logic       chan1_mode_sel;
   logic       wr_value0;
   logic       wr_value1;
   logic       wr_mode;
   logic [7:0] next_mode;

   ////////////////////////////////////////////////////////////////////
   // decode
   assign wr_value0 = I_WR && (I_ADDR == dac_ctrl_pkg::ADDR_VALUE0);
   assign wr_value1 = I_WR && (I_ADDR == dac_ctrl_pkg::ADDR_VALUE1);
   assign wr_mode   = I_WR && (I_ADDR == dac_ctrl_pkg::ADDR_MODE);

   // mode fields
   assign chan0_enable   = converter_mode_ctrl[dac_ctrl_pkg::BIT_CHAN0_EN];
   assign chan1_enable   = converter_mode_ctrl[dac_ctrl_pkg::BIT_CHAN1_EN];
   assign chan0_mode_sel = converter_mode_ctrl[dac_ctrl_pkg::BIT_CHAN0_SEL];
   assign chan1_mode_sel = converter_mode_ctrl[dac_ctrl_pkg::BIT_CHAN1_SEL];

   // next mode value: byte write or single bit write
   always_comb begin
      next_mode = converter_mode_ctrl;
      if (wr_mode) begin
         next_mode = I_WDATA & dac_ctrl_pkg::MODE_WMASK;
      end else if (I_BIT_WR) begin
         next_mode[I_BIT_POS] = I_BIT_VAL;
         next_mode = next_mode & dac_ctrl_pkg::MODE_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mode register
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         converter_mode_ctrl <= dac_ctrl_pkg::RESET_VALUE;
      end else begin
         converter_mode_ctrl <= next_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // channels
   dac_channel u_chan0 (
      .i_clk      (I_REF_CLK),
      .i_rst      (I_RST),
      .i_wr       (wr_value0),
      .i_wdata    (I_WDATA),
      .i_enable   (chan0_enable),
      .i_realtime (chan0_mode_sel),
      .i_trigger  (I_TIMER1_EVENT),
      .o_applied  (chan0_value),
      .o_pending  (O_CHAN0_PENDING),
      .o_code     (O_ANALOG_OUT0),
      .o_drive    (O_ANALOG_OUT0_OE)
   );

   dac_channel u_chan1 (
      .i_clk      (I_REF_CLK),
      .i_rst      (I_RST),
      .i_wr       (wr_value1),
      .i_wdata    (I_WDATA),
      .i_enable   (chan1_enable),
      .i_realtime (chan1_mode_sel),
      .i_trigger  (I_TIMER2_EVENT),
      .o_applied  (chan1_value),
      .o_pending  (O_CHAN1_PENDING),
      .o_code     (O_ANALOG_OUT1),
      .o_drive    (O_ANALOG_OUT1_OE)
   );

   ////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe only
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= dac_ctrl_pkg::READ_ZERO;
      end else if (I_RD) begin
         unique case (I_ADDR)
            dac_ctrl_pkg::ADDR_VALUE0: O_RDATA <= chan0_value;
            dac_ctrl_pkg::ADDR_VALUE1: O_RDATA <= chan1_value;
            dac_ctrl_pkg::ADDR_MODE:   O_RDATA <= converter_mode_ctrl;
            default:                   O_RDATA <= dac_ctrl_pkg::READ_ZERO;
         endcase
      end else begin
         O_RDATA <= dac_ctrl_pkg::READ_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);

   sequence s_rt_write0;
      wr_value0 && chan0_mode_sel && !I_TIMER1_EVENT;
   endsequence

   a_normal_apply0: assert property (
      wr_value0 && !chan0_mode_sel && !$past(I_RST) ##1 !chan0_mode_sel
      |-> ##1 O_ANALOG_OUT0 == $past(I_WDATA, 2))
      else $error("normal write not applied on channel 0");
   a_rt_hold0: assert property (
      s_rt_write0 ##1 (chan0_mode_sel && !I_TIMER1_EVENT && !wr_value0)
      |-> $stable(chan0_value))
      else $error("channel 0 value moved without trigger");
   a_rt_trigger0: assert property (
      O_CHAN0_PENDING && chan0_mode_sel && I_TIMER1_EVENT && !wr_value0
      |=> !O_CHAN0_PENDING)
      else $error("timer 1 event did not release channel 0");
   a_rt_read_old: assert property (
      I_RD && I_ADDR == dac_ctrl_pkg::ADDR_VALUE0 && O_CHAN0_PENDING && chan0_mode_sel
      |=> O_RDATA == $past(chan0_value))
      else $error("realtime read did not show applied value");
   a_hiz_disable: assert property (
      !chan1_enable |=> !O_ANALOG_OUT1_OE)
      else $error("channel 1 driven while disabled");
   a_enable_drive: assert property (
      chan0_enable |=> O_ANALOG_OUT0_OE)
      else $error("channel 0 not driven while enabled");
   a_mode_byte: assert property (
      wr_mode |=> converter_mode_ctrl == ($past(I_WDATA) & dac_ctrl_pkg::MODE_WMASK))
      else $error("mode byte write lost");
   a_rt_trigger1: assert property (
      O_CHAN1_PENDING && chan1_mode_sel && I_TIMER2_EVENT && !wr_value1
      |=> !O_CHAN1_PENDING)
      else $error("timer 2 event did not release channel 1");
   // normal mode on channel 1 never leaves a value waiting for a trigger
   a_mode_sel_bit: assert property (
      !chan1_mode_sel |=> !O_CHAN1_PENDING)
      else $error("channel 1 pending while in normal mode");
endmodule : dac_ctrl

// ==== hdl/dac_ctrl_pkg.sv ====
/*
 * constants for the two-channel converter control block: register
 * indices, mode bit positions, reset values and widths.
 * assumes: included before every design file that uses it.
 */
package dac_ctrl_pkg;
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 2;
   // register indices on the plain register port
   localparam logic [1:0]  ADDR_VALUE0   = 2'h0;
   localparam logic [1:0]  ADDR_VALUE1   = 2'h1;
   localparam logic [1:0]  ADDR_MODE     = 2'h2;
   // mode register fields
   localparam int          BIT_CHAN0_EN  = 0;
   localparam int          BIT_CHAN1_EN  = 1;
   localparam int          BIT_CHAN0_SEL = 4;
   localparam int          BIT_CHAN1_SEL = 5;
   localparam logic [7:0]  MODE_WMASK    = 8'h33;
   localparam logic [7:0]  RESET_VALUE   = 8'h00;
   localparam logic [7:0]  READ_ZERO     = 8'h00;
   localparam logic [8:0]  FULL_SCALE    = 9'h100;
endpackage : dac_ctrl_pkg

// ==== test/dac_ctrl_tb_top.sv ====
/*
 * self-checking bench for the two-channel converter control block.
 * assumes: design files compiled first; bench drives every port itself.
 */
`timescale 1ns/1ns
module dac_ctrl_tb_top;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0, rd = 1'b0, tm1 = 1'b0, tm2 = 1'b0;
   logic       bit_wr = 1'b0, bit_val = 1'b0;
   logic [2:0] bit_pos = 3'h0;
   logic [7:0] rdata, out0, out1;
   logic       oe0, oe1, pend0, pend1;
   int         err_total = 0;
   int         checked = 0;

   dac_ctrl i_dac_ctrl (.I_REF_CLK(ref_clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TIMER1_EVENT(tm1), .I_TIMER2_EVENT(tm2),
      .I_BIT_WR(bit_wr), .I_BIT_POS(bit_pos), .I_BIT_VAL(bit_val),
      .O_ANALOG_OUT0(out0), .O_ANALOG_OUT0_OE(oe0), .O_ANALOG_OUT1(out1),
      .O_ANALOG_OUT1_OE(oe1), .O_CHAN0_PENDING(pend0), .O_CHAN1_PENDING(pend1));

   // 25 MHz reference clock
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare, bus and event tasks
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      rd <= 1'b1; addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 chk("read data", exp, rdata);
   endtask : rd_reg

   task automatic bit_set(input logic [2:0] p, input logic v);
      @(posedge ref_clk);
      bit_wr <= 1'b1; bit_pos <= p; bit_val <= v;
      @(posedge ref_clk);
      bit_wr <= 1'b0;
   endtask : bit_set

   task automatic pulse(input logic which);
      @(posedge ref_clk);
      if (which) tm2 <= 1'b1; else tm1 <= 1'b1;
      @(posedge ref_clk);
      tm1 <= 1'b0; tm2 <= 1'b0;
   endtask : pulse

   // let outputs settle after a request
   task automatic settle();
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic sc_reset();
      rd_reg(dac_ctrl_pkg::ADDR_VALUE0, 8'h00);
      rd_reg(dac_ctrl_pkg::ADDR_VALUE1, 8'h00);
      rd_reg(dac_ctrl_pkg::ADDR_MODE, 8'h00);
      chk("drive enables", 8'h00, {6'h00, oe1, oe0});
   endtask : sc_reset

   // normal mode: value first, then enable; output follows at once
   task automatic sc_normal();
      wr_reg(dac_ctrl_pkg::ADDR_VALUE0, 8'hA5);
      wr_reg(dac_ctrl_pkg::ADDR_VALUE1, 8'h11);
      wr_reg(dac_ctrl_pkg::ADDR_MODE, 8'h03);
      settle();
      chk("code ch0", 8'hA5, out0);
      chk("code ch1", 8'h11, out1);
      chk("drive enables", 8'h03, {6'h00, oe1, oe0});
      rd_reg(dac_ctrl_pkg::ADDR_VALUE0, 8'hA5);
   endtask : sc_normal

   // real-time mode: each channel waits for its own timer event
   task automatic sc_realtime();
      wr_reg(dac_ctrl_pkg::ADDR_MODE, 8'h33);
      wr_reg(dac_ctrl_pkg::ADDR_VALUE0, 8'h5A);
      wr_reg(dac_ctrl_pkg::ADDR_VALUE1, 8'h3C);
      settle();
      chk("pending", 8'h03, {6'h00, pend1, pend0});
      chk("held ch0", 8'hA5, out0);
      rd_reg(dac_ctrl_pkg::ADDR_VALUE1, 8'h11);
      pulse(1'b0);
      settle();
      chk("code ch0", 8'h5A, out0);
      chk("held ch1", 8'h11, out1);
      chk("pending", 8'h02, {6'h00, pend1, pend0});
      pulse(1'b1);
      settle();
      chk("code ch1", 8'h3C, out1);
      rd_reg(dac_ctrl_pkg::ADDR_VALUE1, 8'h3C);
   endtask : sc_realtime

   // reserved bits, single-bit writes and the unmapped index
   task automatic sc_mode_bits();
      wr_reg(dac_ctrl_pkg::ADDR_MODE, 8'h33);
      rd_reg(dac_ctrl_pkg::ADDR_MODE, 8'h33);
      bit_set(3'h4, 1'b0);
      rd_reg(dac_ctrl_pkg::ADDR_MODE, 8'h23);
      bit_set(3'h2, 1'b0);
      rd_reg(dac_ctrl_pkg::ADDR_MODE, 8'h23);
      bit_set(3'h0, 1'b0);
      rd_reg(dac_ctrl_pkg::ADDR_MODE, 8'h22);
      settle();
      chk("drive enables", 8'h02, {6'h00, oe1, oe0});
      wr_reg(2'h3, 8'h55);
      rd_reg(2'h3, 8'h00);
      rd_reg(dac_ctrl_pkg::ADDR_VALUE0, 8'h5A);
   endtask : sc_mode_bits

   ////////////////////////////////////////////////////////////////////////////////
   // verdict
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   // hang guard
   initial begin
      #100000;
      err_total++;
      test_done();
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      sc_reset();
      sc_normal();
      sc_realtime();
      sc_mode_bits();
      test_done();
   end
endmodule : dac_ctrl_tb_top
